// ===== tas_chk_assertions.sv
`timescale 1ns/100ps
// ========================================
// port checker
module tas_chk #(
  parameter int unsigned LSB_CYCLES = tas_pkg::TMR_LSB_CYCLES
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic [7:0]            reg_addr,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [7:0]            reg_wdata,
  input wire logic [7:0]            reg_rdata,
  input wire tas_pkg::tas_cond_type cond,
  input wire logic                  fan_running,
  input wire logic                  boost_full_duty,
  input wire logic                  alert_one_out,
  input wire logic                  alert_one_oe,
  input wire logic                  shared_pin_in,
  input wire logic                  shared_pin_out,
  input wire logic                  shared_pin_oe,
  input wire logic                  fan_four_tach_input,
  input wire logic                  gpio_drive_low,
  input wire logic                  gpio_level,
  input wire logic                  alert_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence rd_two;
    reg_rd && reg_addr == tas_pkg::ADDR_STATUS_TWO;
  endsequence
  sequence rd_one;
    reg_rd && reg_addr == tas_pkg::ADDR_STATUS_ONE;
  endsequence
  // past reset guard: flops see reset-time inputs
  chk_reset_quiet: assert property ($rose(rst_n) |->
    !alert_one_oe && !shared_pin_oe && !boost_full_duty)
    else $error("output active right after reset");
  chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside
    {8'h41, 8'h42, 8'h74, 8'h75, 8'h78, 8'h79, 8'h7A, 8'h7D})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_ovt_sticky: assert property (rd_two ##0 ($past(rst_n) &&
    $past(cond.overtemp)) |=> reg_rdata[1])
    else $error("overtemp status missing");
  chk_summary_bit: assert property (rd_one ##0 ($past(rst_n) &&
    $past(cond.overtemp)) |=> reg_rdata[7])
    else $error("summary bit missing");
  chk_alert_pin: assert property (alert_one_oe |-> alert_active)
    else $error("alert pin without request");
  chk_boost_cause: assert property (boost_full_duty |->
    (fan_running || $past(fan_running)) && !$past(shared_pin_in, 2))
    else $error("boost without cause");
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  chk_alert_sticky: assert property (alert_active && !reg_rd &&
    !reg_wr |=> alert_active) else $error("alert dropped unread");
  chk_tach_follow: assert property (!fan_four_tach_input |->
    !$past(shared_pin_in, 2)) else $error("tach low without pin low");
endmodule : tas_chk

bind tas_top tas_chk #(.LSB_CYCLES(LSB_CYCLES)) u_chk (.*);

// ===== tas_hot_src.sv
`timescale 1ns/100ps
// ========================================
// throttle source on the link clock
module tas_hot_src (
  input  wire logic lclk,
  input  wire logic go,
  input  wire logic dut_pull,
  output logic      pin_n
);
  logic drive_n;
  // pull-up: line idles high between bursts
  initial drive_n = 1'b1;
  always @(posedge lclk) drive_n <= !go;
  // open drain line: either side may pull it low
  assign pin_n = drive_n && !dut_pull;
endmodule : tas_hot_src

// ===== tas_pkg.sv
package tas_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h41;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
  localparam logic [7:0] ADDR_MASK_ONE   = 8'h74;
  localparam logic [7:0] ADDR_MASK_TWO   = 8'h75;
  localparam logic [7:0] ADDR_CONFIG_THR = 8'h78;
  localparam logic [7:0] ADDR_TMR_VALUE  = 8'h79;
  localparam logic [7:0] ADDR_TMR_LIMIT  = 8'h7A;
  localparam logic [7:0] ADDR_CONFIG_FOU = 8'h7D;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_LIMIT  = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;

  // ==========================================================
  // field positions, status/mask one
  localparam int unsigned S1_SUMMARY = 7;
  localparam int unsigned S1_REM_TWO = 6;
  localparam int unsigned S1_LOCAL   = 5;
  localparam int unsigned S1_REM_ONE = 4;
  localparam int unsigned S1_MAIN    = 2;
  localparam int unsigned S1_CORE    = 1;
  localparam int unsigned M1_CORE    = 0;
  // status/mask two
  localparam int unsigned S2_DIODE_2 = 7;
  localparam int unsigned S2_DIODE_1 = 6;
  localparam int unsigned S2_FAN4_TM = 5;
  localparam int unsigned S2_FAN_3   = 4;
  localparam int unsigned S2_FAN_2   = 3;
  localparam int unsigned S2_FAN_1   = 2;
  localparam int unsigned S2_OVTEMP  = 1;
  // config three
  localparam int unsigned C3_ALERT_EN = 0;
  localparam int unsigned C3_THR_EN   = 1;
  localparam int unsigned C3_BOOST    = 2;
  // config four pin function field
  localparam int unsigned C4_FUNC_LO  = 0;

  localparam logic [1:0] PIN_TACH     = 2'h0;
  localparam logic [1:0] PIN_THROTTLE = 2'h1;
  localparam logic [1:0] PIN_ALERT    = 2'h2;
  localparam logic [1:0] PIN_GPIO     = 2'h3;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned TMR_LSB_NS     = 22_760_000; // 22.76 ms
  localparam int unsigned TMR_LSB_CYCLES = TMR_LSB_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  TMR_FULL       = 8'hFF;
  localparam int unsigned SUB_W          = 24;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic rem_two_temp;
    logic local_temp;
    logic rem_one_temp;
    logic main_supply;
    logic core_supply;
    logic diode_two;
    logic diode_one;
    logic fan_four;
    logic fan_three;
    logic fan_two;
    logic fan_one;
    logic overtemp;
  } tas_cond_type;

  typedef struct packed {
    logic             sync1;
    logic             sync2;
    logic [7:0]       st1;
    logic [7:0]       st2;
    logic [7:0]       msk1;
    logic [7:0]       msk2;
    logic [7:0]       cfg3;
    logic [7:0]       cfg4;
    logic [7:0]       lim;
    logic [7:0]       tick;
    logic [SUB_W-1:0] sub;
    logic             seen;
    logic [7:0]       rdata;
  } tas_state_type;

endpackage : tas_pkg

// ===== tas_top.sv
`timescale 1ns/100ps
// Operation
// - status one flags summary, temperatures, supplies
// - status two flags diodes and slow fans
// - bit 5 fan four or timer limit
// - bit 1 flags critical overtemperature
// - bits stick until condition gone and read
// - alert held while out of limit, until read
// - mask gates alert only, status still sets
// - mask one bit assignments
// - mask two bit assignments
// - alert off at reset, config bit enables
// - config four selects shared pin function
// - throttle monitoring needs enable bit too
// - boost forces full duty while pin low
// - boost only when fan already running
// - timer accumulates across throttle assertions
// - timer saturates, cleared only by read
// - bit 0 first assertion, then 22.76 ms LSB
// - read during assertion restarts with bit 0
// - timer read clears fan four/timer status
// - zero limit re-sets status on such read
// - timer above limit sets status, alerts
// - read clears only bits whose cause ended
module tas_top #(
  parameter int unsigned LSB_CYCLES = tas_pkg::TMR_LSB_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_wdata,
  output      logic [7:0]            reg_rdata,
  input  wire tas_pkg::tas_cond_type cond,
  input  wire logic                  fan_running,
  output      logic                  boost_full_duty,
  output      logic                  alert_one_out,
  output      logic                  alert_one_oe,
  input  wire logic                  shared_pin_in,
  output      logic                  shared_pin_out,
  output      logic                  shared_pin_oe,
  output      logic                  fan_four_tach_input,
  input  wire logic                  gpio_drive_low,
  output      logic                  gpio_level,
  output      logic                  alert_active
);

  // ==========================================================
  // helpers
  function automatic logic [7:0] timer_view(input logic [7:0] tick,
                                            input logic       seen);
    // below two whole ticks only the first-assertion bit shows
    if (tick >= 8'h02)
      timer_view = tick;
    else
      timer_view = {7'h00, seen};
  endfunction : timer_view

  function automatic logic [7:0] sticky(input logic [7:0] q,
                                        input logic [7:0] c,
                                        input logic [7:0] clr);
    // a live condition always wins over the clear
    sticky = c | (q & ~(clr & ~c));
  endfunction : sticky

  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] want);
    addr_is = (a == want);
  endfunction : addr_is

  // ==========================================================
  // state
  tas_pkg::tas_state_type q;
  tas_pkg::tas_state_type d;

  logic [1:0] pin_func;
  logic       thr_mode;
  logic       thr_asserted;
  logic       rd_st1;
  logic       rd_st2;
  logic       rd_tmr;
  logic       exceed;
  logic [7:0] c1;
  logic [7:0] c2;
  logic [7:0] clr2;
  logic [7:0] view;
  logic       alert_one_src;
  logic       alert_two_src;
  logic [7:0] gate_one;
  logic [7:0] gate_two;
  logic [7:0] hit_one;
  logic [7:0] hit_two;

  assign pin_func = q.cfg4[tas_pkg::C4_FUNC_LO +: 2];
  // pin must be throttle and monitoring enabled
  assign thr_mode = (pin_func == tas_pkg::PIN_THROTTLE) &&
                    q.cfg3[tas_pkg::C3_THR_EN];
  // throttle signal is active low
  assign thr_asserted = thr_mode && !q.sync2;

  assign rd_st1 = reg_rd && addr_is(reg_addr, tas_pkg::ADDR_STATUS_ONE);
  assign rd_st2 = reg_rd && addr_is(reg_addr, tas_pkg::ADDR_STATUS_TWO);
  assign rd_tmr = reg_rd && addr_is(reg_addr, tas_pkg::ADDR_TMR_VALUE);

  // ==========================================================
  // next state
  always_comb
  begin
    d = q;
    d.sync1 = shared_pin_in;
    d.sync2 = q.sync1;

    // register writes; read-clear registers ignore writes
    if (reg_wr)
    begin
      case (reg_addr)
        tas_pkg::ADDR_MASK_ONE:   d.msk1 = reg_wdata;
        tas_pkg::ADDR_MASK_TWO:   d.msk2 = reg_wdata;
        tas_pkg::ADDR_CONFIG_THR: d.cfg3 = reg_wdata;
        tas_pkg::ADDR_TMR_LIMIT:  d.lim  = reg_wdata;
        tas_pkg::ADDR_CONFIG_FOU: d.cfg4 = reg_wdata;
        default:                  d.lim  = q.lim;
      endcase
    end

    // throttle timer
    if (rd_tmr)
    begin
      d.tick = 8'h00;
      d.sub  = '0;
      d.seen = thr_asserted;
    end
    else if (thr_asserted)
    begin
      d.seen = 1'b1;
      if (q.tick != tas_pkg::TMR_FULL)
      begin
        if (q.sub == LSB_CYCLES[tas_pkg::SUB_W-1:0] - 1'b1)
        begin
          d.sub  = '0;
          d.tick = q.tick + 8'h01;
        end
        else
          d.sub = q.sub + 1'b1;
      end
    end

    // uses the post-read timer so a zero limit re-fires at once
    view   = timer_view(d.tick, d.seen);
    exceed = thr_mode && (view > d.lim);

    c1 = 8'h00;
    c1[tas_pkg::S1_REM_TWO] = cond.rem_two_temp;
    c1[tas_pkg::S1_LOCAL]   = cond.local_temp;
    c1[tas_pkg::S1_REM_ONE] = cond.rem_one_temp;
    c1[tas_pkg::S1_MAIN]    = cond.main_supply;
    c1[tas_pkg::S1_CORE]    = cond.core_supply;

    c2 = 8'h00;
    c2[tas_pkg::S2_DIODE_2] = cond.diode_two;
    c2[tas_pkg::S2_DIODE_1] = cond.diode_one;
    c2[tas_pkg::S2_FAN_3]   = cond.fan_three;
    c2[tas_pkg::S2_FAN_2]   = cond.fan_two;
    c2[tas_pkg::S2_FAN_1]   = cond.fan_one;
    c2[tas_pkg::S2_OVTEMP]  = cond.overtemp;
    c2[tas_pkg::S2_FAN4_TM] = thr_mode ? exceed
                                       : cond.fan_four;

    clr2 = {8{rd_st2}};
    clr2[tas_pkg::S2_FAN4_TM] = rd_st2 || rd_tmr;

    // status sets regardless of the masks
    d.st1 = sticky(q.st1, c1, {8{rd_st1}});
    d.st1[tas_pkg::S1_SUMMARY] = 1'b0;
    d.st2 = sticky(q.st2, c2, clr2);
    d.st2[0] = 1'b0;

    d.rdata = 8'h00;
    case (reg_addr)
      tas_pkg::ADDR_STATUS_ONE:
      begin
        d.rdata = q.st1;
        d.rdata[tas_pkg::S1_SUMMARY] = |q.st2;
      end
      tas_pkg::ADDR_STATUS_TWO: d.rdata = q.st2;
      tas_pkg::ADDR_MASK_ONE:   d.rdata = q.msk1;
      tas_pkg::ADDR_MASK_TWO:   d.rdata = q.msk2;
      tas_pkg::ADDR_CONFIG_THR: d.rdata = q.cfg3;
      tas_pkg::ADDR_TMR_VALUE:  d.rdata = timer_view(q.tick, q.seen);
      tas_pkg::ADDR_TMR_LIMIT:  d.rdata = q.lim;
      tas_pkg::ADDR_CONFIG_FOU: d.rdata = q.cfg4;
      default:                  d.rdata = 8'h00;
    endcase
    if (!reg_rd)
      d.rdata = q.rdata;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q       <= '0;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
      q.st1   <= tas_pkg::RST_STATUS;
      q.st2   <= tas_pkg::RST_STATUS;
      q.msk1  <= tas_pkg::RST_MASK;
      q.msk2  <= tas_pkg::RST_MASK;
      q.cfg3  <= tas_pkg::RST_CONFIG;
      q.cfg4  <= tas_pkg::RST_CONFIG;
      q.lim   <= tas_pkg::RST_LIMIT;
    end
    else
      q <= d;
  end

  // ==========================================================
  // alert and pins
  // sticky bits keep the alert low until read
  // unused status positions stay gated off
  always_comb
  begin
    gate_one = 8'hFF;
    gate_one[tas_pkg::S1_REM_TWO] = q.msk1[tas_pkg::S1_REM_TWO];
    gate_one[tas_pkg::S1_LOCAL]   = q.msk1[tas_pkg::S1_LOCAL];
    gate_one[tas_pkg::S1_REM_ONE] = q.msk1[tas_pkg::S1_REM_ONE];
    gate_one[tas_pkg::S1_MAIN]    = q.msk1[tas_pkg::S1_MAIN];
    // core supply sits at status bit 1 but mask bit 0
    gate_one[tas_pkg::S1_CORE]    = q.msk1[tas_pkg::M1_CORE];
    gate_two    = q.msk2;
    gate_two[0] = 1'b1;
  end

  for (genvar i = 0; i < 8; i++)
  begin : g_alert_bit
    assign hit_one[i] = q.st1[i] && !gate_one[i];
    assign hit_two[i] = q.st2[i] && !gate_two[i];
  end

  assign alert_one_src = |hit_one;
  // summary mask silences every status two source at once
  assign alert_two_src = |hit_two &&
                         !q.msk1[tas_pkg::S1_SUMMARY];
  assign alert_active  = alert_one_src || alert_two_src;

  // open drain: drive low only while alerting
  assign alert_one_out = 1'b0;
  assign alert_one_oe  = q.cfg3[tas_pkg::C3_ALERT_EN] &&
                         alert_active;

  assign shared_pin_out = 1'b0;
  assign shared_pin_oe  =
    ((pin_func == tas_pkg::PIN_ALERT) && alert_active) ||
    ((pin_func == tas_pkg::PIN_GPIO) && gpio_drive_low);
  assign fan_four_tach_input = (pin_func == tas_pkg::PIN_TACH) ?
                               q.sync2 : 1'b1;
  assign gpio_level = q.sync2;

  // boost cannot start a stopped fan
  assign boost_full_duty = q.cfg3[tas_pkg::C3_BOOST] && thr_asserted &&
                           fan_running;

  assign reg_rdata = q.rdata;

endmodule : tas_top

// ===== tb_tas_top.sv
`timescale 1ns/100ps
// ========================================
// bench
module tb_tas_top;
  localparam int unsigned LSBC = 5;
  logic                  clk;
  logic                  lclk;
  logic                  rst_n = 1'b0;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [7:0]            reg_addr = 8'h00;
  logic [7:0]            reg_wdata = 8'h00;
  logic [7:0]            reg_rdata;
  tas_pkg::tas_cond_type cond = '0;
  logic                  fan_running = 1'b0;
  logic                  gpio_drive_low = 1'b0;
  logic                  go = 1'b0;
  logic boost_full_duty, alert_one_out, alert_one_oe, shared_pin_in;
  logic shared_pin_out, shared_pin_oe, fan_four_tach_input, gpio_level;
  logic                  alert_active;
  logic [31:0]           seed = 32'h6E86;
  logic [11:0]           c;
  logic [7:0]            m1;
  logic [7:0]            m2;
  logic [7:0]            rw [3] = '{8'h74, 8'h75, 8'h7A};
  int                    fail_count = 0;
  int                    check_count = 0;
  int                    cyc = 0;

  tas_top #(.LSB_CYCLES(LSBC)) dut (.*);
  tas_hot_src src (
    .lclk     (lclk),
    .go       (go),
    .dut_pull (shared_pin_oe),
    .pin_n    (shared_pin_in)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // link clock unrelated in phase to clk
  initial
  begin
    lclk = 1'b0;
    #137;
    forever #400 lclk = ~lclk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  // ========================================
  // expectations
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] s1(input logic [11:0] v);
    return {|v[6:0], v[11:9], 1'b0, v[8:7], 1'b0};
  endfunction : s1
  function automatic logic [7:0] s2(input logic [11:0] v);
    return {v[6:0], 1'b0};
  endfunction : s2
  function automatic logic alrt(input logic [11:0] v, input logic [7:0] a,
                                input logic [7:0] b);
    logic [7:0] x;
    logic [7:0] y;
    x = s1(v);
    y = s2(v);
    return |(x[6:1] & ~{a[6:2], a[0]}) | (!a[7] & |(y[7:1] & ~b[7:1]));
  endfunction : alrt
  // view of the timer after n asserted cycles
  function automatic logic [7:0] tv(input int n);
    return (n / LSBC >= 2) ? 8'(n / LSBC) : 8'h01;
  endfunction : tv

  // ========================================
  // tasks
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : ck
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 ck(reg_rdata, e);
  endtask : rc
  // pin low for k link periods, then released
  task automatic burst(input int k);
    @(posedge clk) go <= 1'b1;
    repeat (k) @(posedge lclk);
    @(posedge clk) go <= 1'b0;
    repeat (2) @(posedge lclk);
  endtask : burst
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // ========================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rw[i]) rc(rw[i], 8'h00);
    rc(8'h78, 8'h00);
    rc(8'h40, 8'h00);
    wr(8'h42, 8'hFF);
    rc(8'h42, 8'h00);
    foreach (rw[i])
    begin
      seed = lfsr(seed);
      wr(rw[i], seed[7:0]);
      rc(rw[i], seed[7:0]);
    end
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      c = (k == 0) ? 12'hFFF : seed[11:0];
      m1 = (k == 0) ? 8'h00 : seed[19:12];
      m2 = seed[27:20];
      wr(8'h74, m1);
      wr(8'h75, m2);
      @(posedge clk) cond <= tas_pkg::tas_cond_type'(c);
      @(posedge clk) cond <= '0;
      #1 ck({6'h00, alert_one_oe, alert_active},
            {7'h00, alrt(c, m1, m2)});
      rc(8'h41, s1(c));
      rc(8'h42, s2(c));
      rc(8'h41, 8'h00);
    end
    wr(8'h74, 8'h00);
    wr(8'h75, 8'h00);
    wr(8'h78, 8'h01);
    @(posedge clk) cond <= tas_pkg::tas_cond_type'(12'h001);
    rc(8'h42, 8'h02);
    rc(8'h41, 8'h80);
    rc(8'h42, 8'h02);
    for (int m = 0; m < 5; m++)
    begin
      @(posedge clk) gpio_drive_low <= (m == 4);
      // last pass pulls the pin low in general-purpose mode
      wr(8'h7D, (m == 4) ? 8'h03 : 8'(m));
      #1 ck({4'h0, alert_one_oe, shared_pin_oe, fan_four_tach_input,
            alert_active}, {5'h01, m == 2 || m == 4, 2'h3});
    end
    #1 ck({7'h00, gpio_level}, 8'h00);
    wr(8'h75, 8'h02);
    #1 ck({6'h00, alert_one_oe, alert_active}, 8'h00);
    @(posedge clk) cond <= '0;
    gpio_drive_low <= 1'b0;
    rc(8'h42, 8'h02);
    rc(8'h42, 8'h00);
    ck({7'h00, gpio_level}, 8'h01);
    wr(8'h75, 8'h00);
    wr(8'h7D, 8'h01);
    wr(8'h78, 8'h00);
    burst(2);
    rc(8'h79, 8'h00);
    wr(8'h78, 8'h02);
    wr(8'h7A, 8'h01);
    burst(1);
    rc(8'h79, tv(8));
    rc(8'h42, 8'h00);
    burst(2);
    burst(2);
    ck({7'h00, alert_active}, 8'h01);
    rc(8'h79, tv(32));
    rc(8'h42, 8'h00);
    burst(170);
    rc(8'h79, 8'hFF);
    rc(8'h79, 8'h00);
    wr(8'h7A, 8'h00);
    wr(8'h78, 8'h06);
    @(posedge clk) fan_running <= 1'b1;
    go <= 1'b1;
    repeat (3) @(posedge lclk);
    ck({7'h00, boost_full_duty}, 8'h01);
    // pin low from the first link edge, counted from the third clock
    rc(8'h79, tv(15));
    rc(8'h79, 8'h01);
    rc(8'h42, 8'h20);
    @(posedge clk) fan_running <= 1'b0;
    repeat (2) @(posedge clk);
    #1 ck({7'h00, boost_full_duty}, 8'h00);
    wr(8'h7D, 8'h00);
    repeat (3) @(posedge clk);
    #1 ck({7'h00, fan_four_tach_input}, 8'h00);
    ck({6'h00, alert_one_out, shared_pin_out}, 8'h00);
    @(posedge clk) go <= 1'b0;
    give_verdict();
  end
endmodule : tb_tas_top
